// *** pkg/crag_pkg.sv ***
package crag_pkg;
    // ****************************************
    // Register offsets.
    // ****************************************
    localparam logic [6:0] OFF_FRAME_PTR = 7'h1c;
    localparam logic [6:0] OFF_STACK_PTR = 7'h1e;
    localparam logic [6:0] OFF_STACK_LIM = 7'h20;
    localparam logic [6:0] OFF_ACCA_LO = 7'h22;
    localparam logic [6:0] OFF_ACCA_HI = 7'h24;
    localparam logic [6:0] OFF_ACCA_UP = 7'h26;
    localparam logic [6:0] OFF_ACCB_LO = 7'h28;
    localparam logic [6:0] OFF_ACCB_HI = 7'h2a;
    localparam logic [6:0] OFF_ACCB_UP = 7'h2c;
    localparam logic [6:0] OFF_PC_LO = 7'h2e;
    localparam logic [6:0] OFF_PC_HI = 7'h30;
    localparam logic [6:0] OFF_TBL_PAGE = 7'h32;
    localparam logic [6:0] OFF_CONST_PAGE = 7'h34;
    localparam logic [6:0] OFF_REPEAT_CNT = 7'h36;
    localparam logic [6:0] OFF_LOOP_CNT = 7'h38;
    localparam logic [6:0] OFF_LOOP_START_LO = 7'h3a;
    localparam logic [6:0] OFF_LOOP_START_HI = 7'h3c;
    localparam logic [6:0] OFF_LOOP_END_LO = 7'h3e;
    localparam logic [6:0] OFF_LOOP_END_HI = 7'h40;
    localparam logic [6:0] OFF_STATUS = 7'h42;
    localparam logic [6:0] OFF_CORE_CTRL = 7'h44;
    localparam logic [6:0] OFF_CIRC_CTRL = 7'h46;
    localparam logic [6:0] OFF_X_CIRC_START = 7'h48;
    localparam logic [6:0] OFF_X_CIRC_END = 7'h4a;
    localparam logic [6:0] OFF_Y_CIRC_START = 7'h4c;
    localparam logic [6:0] OFF_Y_CIRC_END = 7'h4e;
    localparam logic [6:0] OFF_X_BITREV = 7'h50;
    localparam logic [6:0] OFF_IRQ_DIS_CNT = 7'h52;
    // ****************************************
    // Implemented bit masks and reset values.
    // ****************************************
    localparam logic [15:0] MASK_FULL = 16'hffff;
    localparam logic [15:0] MASK_ACC_UP = 16'h00ff;
    localparam logic [15:0] MASK_PC_HI = 16'h007f;
    localparam logic [15:0] MASK_PAGE = 16'h00ff;
    localparam logic [15:0] MASK_LOOP_LO = 16'hfffe;
    localparam logic [15:0] MASK_LOOP_HI = 16'h007f;
    localparam logic [15:0] MASK_CORE_CTRL = 16'h1fff;
    localparam logic [15:0] MASK_CIRC_CTRL = 16'hcfff;
    localparam logic [15:0] MASK_CIRC_START = 16'hfffe;
    localparam logic [15:0] MASK_IRQ_DIS = 16'h3fff;
    localparam logic [15:0] CIRC_END_LSB = 16'h0001;
    localparam logic [15:0] RST_STACK_PTR = 16'h0800;
    localparam logic [15:0] RST_CORE_CTRL = 16'h0020;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] STACK_FLOOR = 16'h0800;
    localparam int SAT_DW_BIT = 5;
    localparam int CIRC_X_EN_BIT = 15;
    localparam int CIRC_Y_EN_BIT = 14;
    localparam int BITREV_EN_BIT = 15;
    // ****************************************
    // Address sequencing kinds.
    // ****************************************
    typedef enum logic [1:0] {
        CRAG_SEQ_LINEAR,
        CRAG_SEQ_CIRC,
        CRAG_SEQ_BITREV
    } crag_seq_t;
endpackage : crag_pkg

// *** pkg/crag_agu_if.sv ***
`timescale 1ns/1ns
interface crag_agu_if;
    logic req;
    logic [15:0] base;
    logic [15:0] step;
    logic prog_space;
    logic [15:0] addr;
    logic seq_circ;
    logic seq_bitrev;
    modport gen (input req, input base, input step, input prog_space, output addr,
        output seq_circ, output seq_bitrev);
    modport user (output req, output base, output step, output prog_space, input addr,
        input seq_circ, input seq_bitrev);
endinterface : crag_agu_if

// *** src/crag_agu.sv ***
`timescale 1ns/1ns
module crag_agu #(
    parameter int AW = 16
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_b,
    // Sequencing setup.
    input wire logic circ_en,
    input wire logic [15:0] circ_start,
    input wire logic [15:0] circ_end,
    input wire logic bitrev_en,
    input wire logic [15:0] bitrev_mod,
    // Address path.
    crag_agu_if.gen agu
);
    import crag_pkg::*;

    if (AW != 16) begin : g_aw_check
        $error("crag_agu supports only 16-bit addresses.");
    end

    logic [15:0] next_lin;
    logic [15:0] next_addr;
    logic [15:0] rev_sum;

    // Reverse-carry add for bit-reversed stepping.
    function automatic logic [15:0] rev_add(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] ra;
        logic [15:0] rb;
        logic [15:0] rs;
        ra = {<<{a}};
        rb = {<<{b}};
        rs = 16'(ra + rb);
        return {<<{rs}};
    endfunction : rev_add

    assign next_lin = 16'(agu.base + agu.step);
    assign rev_sum = rev_add(agu.base, bitrev_mod);

    // ****************************************
    // Linear, circular, bit-reversed sequencing.
    // ****************************************
    always_comb begin
        next_addr = next_lin;
        agu.seq_circ = 1'b0;
        agu.seq_bitrev = 1'b0;
        if (bitrev_en && !agu.prog_space) begin
            next_addr = rev_sum;
            agu.seq_bitrev = 1'b1;
        end else if (circ_en) begin
            agu.seq_circ = 1'b1;
            if (next_lin > circ_end) begin
                next_addr = 16'(circ_start + (next_lin - circ_end) - 16'h0001);
            end else if (next_lin < circ_start) begin
                next_addr = 16'(circ_end - (circ_start - next_lin) + 16'h0001);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            agu.addr <= RST_ZERO;
        end else if (agu.req) begin
            agu.addr <= next_addr;
        end
    end
endmodule : crag_agu

// *** src/crag_regs.sv ***
// Operation
// - Two independent address generators, primary and secondary.
// - Secondary generator serves only word dual-operand reads.
// - Linear, circular and bit-reversed sequencing.
// - Linear and circular work in program space too.
// - Bit-reversal never applied to program space.
// - Unimplemented bits read zero, except accumulator upper sign extension and circular end bit 0 reading one; writes ignored.
// - Stack pointer resets 0x0800; repeat, loop, circular bound and bit-reverse registers not reset; others except core control zero.
// - Core control resets 0x0020, write saturation.
// - Loop low halves hold bit 0 zero.
// - Loop high halves implement bits 6:0 only.
// - Stack address below 0x0800 raises stack trap.
`timescale 1ns/1ns
module crag_regs (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port.
    input wire logic [6:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Primary address generator.
    input wire logic x_req,
    input wire logic [15:0] x_base,
    input wire logic [15:0] x_step,
    input wire logic x_prog_space,
    input wire logic x_stack_use,
    output logic [15:0] x_addr,
    output logic x_circ_active,
    output logic x_bitrev_active,
    // Secondary address generator.
    input wire logic y_req,
    input wire logic y_mac_word_read,
    input wire logic [15:0] y_base,
    input wire logic [15:0] y_step,
    output logic [15:0] y_addr,
    output logic y_circ_active,
    // Status outputs.
    output logic stack_error_trap,
    output logic data_write_saturation_enable
);
    import crag_pkg::*;

    // ****************************************
    // Register storage.
    // ****************************************
    logic [15:0] frame_pointer_reg_q;
    logic [15:0] stack_pointer_reg_q;
    logic [15:0] stack_limit_reg_q;
    logic [15:0] accum_a_low_q;
    logic [15:0] accum_a_high_q;
    logic [15:0] accum_a_upper_q;
    logic [15:0] accum_b_low_q;
    logic [15:0] accum_b_high_q;
    logic [15:0] accum_b_upper_q;
    logic [15:0] program_counter_low_q;
    logic [15:0] program_counter_high_q;
    logic [15:0] table_access_page_q;
    logic [15:0] const_window_page_q;
    logic [15:0] core_status_flags_q;
    logic [15:0] core_control_q;
    logic [15:0] circ_buffer_control_q;
    logic [15:0] irq_disable_counter_q;
    logic [15:0] repeat_loop_count_q;
    logic [15:0] hw_loop_count_q;
    logic [15:1] loop_start_addr_low_q;
    logic [6:0] loop_start_addr_high_q;
    logic [15:1] loop_end_addr_low_q;
    logic [6:0] loop_end_addr_high_q;
    logic [15:0] x_circ_start_addr_q;
    logic [15:0] x_circ_end_addr_q;
    logic [15:0] y_circ_start_addr_q;
    logic [15:0] y_circ_end_addr_q;
    logic [15:0] x_bit_reverse_control_q;
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    logic trap_q;

    // Sign extension of accumulator guard byte into upper bits.
    function automatic logic [15:0] sext_up(input logic [15:0] v);
        return {{8{v[7]}}, v[7:0]};
    endfunction : sext_up

    function automatic logic hit(input logic [6:0] a, input logic [6:0] off, input logic s);
        return s && (a == off);
    endfunction : hit

    // ****************************************
    // Reset-initialised registers.
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_pointer_reg_q <= RST_ZERO;
            stack_pointer_reg_q <= RST_STACK_PTR;
            stack_limit_reg_q <= RST_ZERO;
            accum_a_low_q <= RST_ZERO;
            accum_a_high_q <= RST_ZERO;
            accum_a_upper_q <= RST_ZERO;
            accum_b_low_q <= RST_ZERO;
            accum_b_high_q <= RST_ZERO;
            accum_b_upper_q <= RST_ZERO;
            program_counter_low_q <= RST_ZERO;
            program_counter_high_q <= RST_ZERO;
            table_access_page_q <= RST_ZERO;
            const_window_page_q <= RST_ZERO;
            core_status_flags_q <= RST_ZERO;
            core_control_q <= RST_CORE_CTRL;
            circ_buffer_control_q <= RST_ZERO;
            irq_disable_counter_q <= RST_ZERO;
        end else if (reg_wr) begin
            if (hit(reg_addr, OFF_FRAME_PTR, 1'b1)) frame_pointer_reg_q <= reg_wdata;
            if (hit(reg_addr, OFF_STACK_PTR, 1'b1)) stack_pointer_reg_q <= reg_wdata;
            if (hit(reg_addr, OFF_STACK_LIM, 1'b1)) stack_limit_reg_q <= reg_wdata;
            if (hit(reg_addr, OFF_ACCA_LO, 1'b1)) accum_a_low_q <= reg_wdata;
            if (hit(reg_addr, OFF_ACCA_HI, 1'b1)) accum_a_high_q <= reg_wdata;
            if (hit(reg_addr, OFF_ACCA_UP, 1'b1)) accum_a_upper_q <= reg_wdata & MASK_ACC_UP;
            if (hit(reg_addr, OFF_ACCB_LO, 1'b1)) accum_b_low_q <= reg_wdata;
            if (hit(reg_addr, OFF_ACCB_HI, 1'b1)) accum_b_high_q <= reg_wdata;
            if (hit(reg_addr, OFF_ACCB_UP, 1'b1)) accum_b_upper_q <= reg_wdata & MASK_ACC_UP;
            if (hit(reg_addr, OFF_PC_LO, 1'b1)) program_counter_low_q <= reg_wdata;
            if (hit(reg_addr, OFF_PC_HI, 1'b1)) begin
                program_counter_high_q <= reg_wdata & MASK_PC_HI;
            end
            if (hit(reg_addr, OFF_TBL_PAGE, 1'b1)) table_access_page_q <= reg_wdata & MASK_PAGE;
            if (hit(reg_addr, OFF_CONST_PAGE, 1'b1)) begin
                const_window_page_q <= reg_wdata & MASK_PAGE;
            end
            if (hit(reg_addr, OFF_STATUS, 1'b1)) core_status_flags_q <= reg_wdata;
            if (hit(reg_addr, OFF_CORE_CTRL, 1'b1)) begin
                core_control_q <= reg_wdata & MASK_CORE_CTRL;
            end
            if (hit(reg_addr, OFF_CIRC_CTRL, 1'b1)) begin
                circ_buffer_control_q <= reg_wdata & MASK_CIRC_CTRL;
            end
            if (hit(reg_addr, OFF_IRQ_DIS_CNT, 1'b1)) begin
                irq_disable_counter_q <= reg_wdata & MASK_IRQ_DIS;
            end
        end
    end

    // ****************************************
    // Registers left uninitialised by reset.
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (reg_wr) begin
            if (hit(reg_addr, OFF_REPEAT_CNT, 1'b1)) repeat_loop_count_q <= reg_wdata;
            if (hit(reg_addr, OFF_LOOP_CNT, 1'b1)) hw_loop_count_q <= reg_wdata;
            if (hit(reg_addr, OFF_X_CIRC_START, 1'b1)) begin
                x_circ_start_addr_q <= reg_wdata & MASK_CIRC_START;
            end
            if (hit(reg_addr, OFF_X_CIRC_END, 1'b1)) begin
                x_circ_end_addr_q <= reg_wdata | CIRC_END_LSB;
            end
            if (hit(reg_addr, OFF_Y_CIRC_START, 1'b1)) begin
                y_circ_start_addr_q <= reg_wdata & MASK_CIRC_START;
            end
            if (hit(reg_addr, OFF_Y_CIRC_END, 1'b1)) begin
                y_circ_end_addr_q <= reg_wdata | CIRC_END_LSB;
            end
            if (hit(reg_addr, OFF_X_BITREV, 1'b1)) x_bit_reverse_control_q <= reg_wdata;
        end
    end

    // Loop bounds store only their implemented bits; the fixed bits are supplied on read.
    always_ff @(posedge core_clk) begin
        if (reg_wr && reg_addr == OFF_LOOP_START_LO) begin
            loop_start_addr_low_q <= reg_wdata[15:1];
        end
        if (reg_wr && reg_addr == OFF_LOOP_END_LO) begin
            loop_end_addr_low_q <= reg_wdata[15:1];
        end
        if (reg_wr && reg_addr == OFF_LOOP_START_HI) begin
            loop_start_addr_high_q <= reg_wdata[6:0];
        end
        if (reg_wr && reg_addr == OFF_LOOP_END_HI) begin
            loop_end_addr_high_q <= reg_wdata[6:0];
        end
    end

    // ****************************************
    // Read path, data one cycle after the strobe.
    // ****************************************
    always_comb begin
        unique case (reg_addr)
            OFF_FRAME_PTR: rdata_d = frame_pointer_reg_q;
            OFF_STACK_PTR: rdata_d = stack_pointer_reg_q;
            OFF_STACK_LIM: rdata_d = stack_limit_reg_q;
            OFF_ACCA_LO: rdata_d = accum_a_low_q;
            OFF_ACCA_HI: rdata_d = accum_a_high_q;
            OFF_ACCA_UP: rdata_d = sext_up(accum_a_upper_q);
            OFF_ACCB_LO: rdata_d = accum_b_low_q;
            OFF_ACCB_HI: rdata_d = accum_b_high_q;
            OFF_ACCB_UP: rdata_d = sext_up(accum_b_upper_q);
            OFF_PC_LO: rdata_d = program_counter_low_q;
            OFF_PC_HI: rdata_d = program_counter_high_q;
            OFF_TBL_PAGE: rdata_d = table_access_page_q;
            OFF_CONST_PAGE: rdata_d = const_window_page_q;
            OFF_REPEAT_CNT: rdata_d = repeat_loop_count_q;
            OFF_LOOP_CNT: rdata_d = hw_loop_count_q;
            OFF_LOOP_START_LO: rdata_d = {loop_start_addr_low_q, 1'b0};
            OFF_LOOP_START_HI: rdata_d = {9'h000, loop_start_addr_high_q};
            OFF_LOOP_END_LO: rdata_d = {loop_end_addr_low_q, 1'b0};
            OFF_LOOP_END_HI: rdata_d = {9'h000, loop_end_addr_high_q};
            OFF_STATUS: rdata_d = core_status_flags_q;
            OFF_CORE_CTRL: rdata_d = core_control_q;
            OFF_CIRC_CTRL: rdata_d = circ_buffer_control_q;
            OFF_X_CIRC_START: rdata_d = x_circ_start_addr_q;
            OFF_X_CIRC_END: rdata_d = x_circ_end_addr_q;
            OFF_Y_CIRC_START: rdata_d = y_circ_start_addr_q;
            OFF_Y_CIRC_END: rdata_d = y_circ_end_addr_q;
            OFF_X_BITREV: rdata_d = x_bit_reverse_control_q;
            OFF_IRQ_DIS_CNT: rdata_d = irq_disable_counter_q;
            default: rdata_d = RST_ZERO;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= RST_ZERO;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= RST_ZERO;
        end
    end

    assign reg_rdata = rdata_q;
    assign data_write_saturation_enable = core_control_q[SAT_DW_BIT];

    // ****************************************
    // Address generators.
    // ****************************************
    crag_agu_if x_if ();
    crag_agu_if y_if ();

    assign x_if.req = x_req;
    assign x_if.base = x_base;
    assign x_if.step = x_step;
    assign x_if.prog_space = x_prog_space;
    // The secondary unit only advances on word reads of the dual-operand class.
    assign y_if.req = y_req && y_mac_word_read;
    assign y_if.base = {y_base[15:1], 1'b0};
    assign y_if.step = {y_step[15:1], 1'b0};
    assign y_if.prog_space = 1'b0;

    crag_agu #(.AW(16)) u_primary_address_generator (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .circ_en(circ_buffer_control_q[CIRC_X_EN_BIT]),
        .circ_start(x_circ_start_addr_q),
        .circ_end(x_circ_end_addr_q),
        .bitrev_en(x_bit_reverse_control_q[BITREV_EN_BIT]),
        .bitrev_mod({1'b0, x_bit_reverse_control_q[14:0]}),
        .agu(x_if.gen)
    );

    crag_agu #(.AW(16)) u_secondary_address_generator (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .circ_en(circ_buffer_control_q[CIRC_Y_EN_BIT]),
        .circ_start(y_circ_start_addr_q),
        .circ_end(y_circ_end_addr_q),
        .bitrev_en(1'b0),
        .bitrev_mod(RST_ZERO),
        .agu(y_if.gen)
    );

    assign x_addr = x_if.addr;
    assign x_circ_active = x_if.seq_circ;
    assign x_bitrev_active = x_if.seq_bitrev;
    assign y_addr = y_if.addr;
    assign y_circ_active = y_if.seq_circ;

    // ****************************************
    // Stack underflow trap.
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            trap_q <= 1'b0;
        end else begin
            trap_q <= x_req && x_stack_use && (x_base < STACK_FLOOR);
        end
    end

    assign stack_error_trap = trap_q;
endmodule : crag_regs

// *** sim/crag_regs_properties.sv ***
`timescale 1ns/1ns
module crag_regs_properties (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port.
    input wire logic [6:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Address generators.
    input wire logic x_req,
    input wire logic [15:0] x_base,
    input wire logic [15:0] x_step,
    input wire logic x_prog_space,
    input wire logic x_stack_use,
    input wire logic [15:0] x_addr,
    input wire logic x_circ_active,
    input wire logic x_bitrev_active,
    input wire logic y_req,
    input wire logic y_mac_word_read,
    input wire logic [15:0] y_addr,
    // Status.
    input wire logic stack_error_trap,
    input wire logic data_write_saturation_enable
);
    import crag_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ****************************************
    // Register port.
    // ****************************************
    chk_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == RST_ZERO)
        else $error("read data not zero outside read cycle");
    chk_pc_hi_bits: assert property ($past(reg_rd) && $past(reg_addr) == OFF_PC_HI
        |-> (reg_rdata & ~MASK_PC_HI) == 16'h0000) else $error("pc high spare bits set");
    chk_unmapped_zero: assert property ($past(reg_rd)
        && $past(reg_addr) > OFF_IRQ_DIS_CNT |-> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_loop_lo_lsb: assert property ($past(reg_rd)
        && ($past(reg_addr) == OFF_LOOP_START_LO || $past(reg_addr) == OFF_LOOP_END_LO)
        |-> reg_rdata[0] == 1'b0) else $error("loop low bit 0 set");
    chk_loop_hi_top: assert property ($past(reg_rd)
        && ($past(reg_addr) == OFF_LOOP_START_HI || $past(reg_addr) == OFF_LOOP_END_HI)
        |-> reg_rdata[15:7] == 9'h000) else $error("loop high upper bits set");
    chk_sat_follow: assert property ($past(reg_wr) && $past(reg_addr) == OFF_CORE_CTRL
        |-> data_write_saturation_enable == (($past(reg_wdata) & 16'h0020) != 16'h0000))
        else $error("saturation enable does not follow write");
    // ****************************************
    // Address generators and stack check.
    // ****************************************
    chk_trap_raise: assert property (x_req && x_stack_use && x_base < STACK_FLOOR
        |=> stack_error_trap) else $error("stack trap missing");
    chk_trap_cause: assert property (stack_error_trap |-> $past(x_req)
        && $past(x_stack_use) && $past(x_base) < STACK_FLOOR)
        else $error("stack trap without cause");
    chk_x_linear: assert property (x_req && !x_circ_active && !x_bitrev_active
        |=> x_addr == $past(x_base) + $past(x_step)) else $error("linear address wrong");
    chk_y_mac_only: assert property (!(y_req && y_mac_word_read) |=> $stable(y_addr))
        else $error("secondary address moved without word read");
    chk_bitrev_prog: assert property (x_prog_space |-> !x_bitrev_active)
        else $error("bit reversal in program space");
    chk_x_hold: assert property (!x_req |=> $stable(x_addr))
        else $error("primary address moved without request");
endmodule : crag_regs_properties

bind crag_regs crag_regs_properties u_chk (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .x_req(x_req), .x_base(x_base), .x_step(x_step),
    .x_prog_space(x_prog_space), .x_stack_use(x_stack_use), .x_addr(x_addr),
    .x_circ_active(x_circ_active), .x_bitrev_active(x_bitrev_active), .y_req(y_req),
    .y_mac_word_read(y_mac_word_read), .y_addr(y_addr), .stack_error_trap(stack_error_trap),
    .data_write_saturation_enable(data_write_saturation_enable));

// *** sim/test_crag_regs.sv ***
`timescale 1ns/1ns
module test_crag_regs;
    import crag_pkg::*;
    logic core_clk, rst_b, reg_wr, reg_rd, x_req, x_prog_space, x_stack_use, y_req;
    logic y_mac_word_read, x_circ_active, x_bitrev_active, y_circ_active;
    logic stack_error_trap, data_write_saturation_enable;
    logic [6:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, x_base, x_step, x_addr, y_base, y_step, y_addr;
    int n_mismatch, n_tests;
    localparam logic [6:0] MOFF [16] = '{7'h1c, 7'h22, 7'h2e, 7'h30, 7'h32, 7'h34, 7'h36,
        7'h3a, 7'h3c, 7'h3e, 7'h40, 7'h44, 7'h46, 7'h48, 7'h4a, 7'h52};
    localparam logic [15:0] MEXP [16] = '{MASK_FULL, MASK_FULL, MASK_FULL, MASK_PC_HI,
        MASK_PAGE, MASK_PAGE, MASK_FULL, MASK_LOOP_LO, MASK_LOOP_HI, MASK_LOOP_LO,
        MASK_LOOP_HI, MASK_CORE_CTRL, MASK_CIRC_CTRL, MASK_CIRC_START, MASK_FULL, MASK_IRQ_DIS};
    crag_regs u_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .x_req(x_req), .x_base(x_base), .x_step(x_step), .x_prog_space(x_prog_space),
        .x_stack_use(x_stack_use), .x_addr(x_addr), .x_circ_active(x_circ_active),
        .x_bitrev_active(x_bitrev_active), .y_req(y_req), .y_mac_word_read(y_mac_word_read),
        .y_base(y_base), .y_step(y_step), .y_addr(y_addr), .y_circ_active(y_circ_active),
        .stack_error_trap(stack_error_trap),
        .data_write_saturation_enable(data_write_saturation_enable));
    // ****************************************
    // Bus and address generator drivers.
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // The secondary generator is always asked; ym says whether it is a word read.
    task automatic agu(input logic [15:0] xb, input logic [15:0] xs, input logic xp,
        input logic xsu, input logic ym, input logic [15:0] yb);
        @(posedge core_clk);
        x_req <= 1'b1;
        x_base <= xb;
        x_step <= xs;
        x_prog_space <= xp;
        x_stack_use <= xsu;
        y_req <= 1'b1;
        y_mac_word_read <= ym;
        y_base <= yb;
        @(posedge core_clk);
        x_req <= 1'b0;
        y_req <= 1'b0;
        #1;
    endtask : agu
    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic t_reset;
        logic [15:0] v;
        logic [15:0] e;
        for (int a = 'h1c; a <= 'h52; a += 2) begin
            if ((a >= 'h36 && a <= 'h40) || (a >= 'h48 && a <= 'h50)) continue;
            rd(7'(a), v);
            e = (a == 'h1e) ? RST_STACK_PTR : (a == 'h44) ? RST_CORE_CTRL : RST_ZERO;
            check(v, e);
        end
        check(16'(data_write_saturation_enable), 16'h0001);
    endtask : t_reset
    task automatic t_masks;
        logic [15:0] v;
        for (int i = 0; i < 16; i++) begin
            wr(MOFF[i], 16'hffff);
            rd(MOFF[i], v);
            check(v, MEXP[i]);
        end
        wr(OFF_ACCA_UP, 16'h0080);
        rd(OFF_ACCA_UP, v);
        check(v, 16'hff80);
        wr(7'h54, 16'hffff);
        rd(7'h54, v);
        check(v, 16'h0000);
        wr(OFF_CORE_CTRL, 16'hffdf);
        check(16'(data_write_saturation_enable), 16'h0000);
        wr(OFF_CORE_CTRL, RST_CORE_CTRL);
        check(16'(data_write_saturation_enable), 16'h0001);
    endtask : t_masks
    task automatic t_circ;
        wr(OFF_X_CIRC_START, 16'h1000);
        wr(OFF_X_CIRC_END, 16'h100f);
        wr(OFF_Y_CIRC_START, 16'h2000);
        wr(OFF_Y_CIRC_END, 16'h2007);
        wr(OFF_X_BITREV, 16'h0000);
        wr(OFF_CIRC_CTRL, 16'hc000);
        agu(16'h100e, 16'h0002, 1'b0, 1'b0, 1'b1, 16'h2006);
        check(x_addr, 16'h1000);
        check(y_addr, 16'h2000);
        check(16'({x_circ_active, y_circ_active}), 16'h0003);
        agu(16'h100e, 16'h0002, 1'b1, 1'b0, 1'b0, 16'h2002);
        check(x_addr, 16'h1000);
        check(y_addr, 16'h2000);
    endtask : t_circ
    task automatic t_bitrev;
        wr(OFF_CIRC_CTRL, 16'h0000);
        wr(OFF_X_BITREV, 16'h8008);
        agu(16'h1008, 16'h0008, 1'b0, 1'b0, 1'b1, 16'h0400);
        check(x_addr, 16'h1004);
        check(16'(x_bitrev_active), 16'h0001);
        check(y_addr, 16'h0402);
        agu(16'h1008, 16'h0008, 1'b1, 1'b0, 1'b1, 16'h0400);
        check(x_addr, 16'h1010);
        check(16'(x_bitrev_active), 16'h0000);
    endtask : t_bitrev
    task automatic t_stack;
        wr(OFF_X_BITREV, 16'h0000);
        agu(16'h07fe, 16'h0002, 1'b0, 1'b1, 1'b0, 16'h0000);
        check(16'(stack_error_trap), 16'h0001);
        check(x_addr, 16'h0800);
        agu(16'h0800, 16'h0002, 1'b0, 1'b1, 1'b0, 16'h0000);
        check(16'(stack_error_trap), 16'h0000);
    endtask : t_stack
    // ****************************************
    // Run control.
    // ****************************************
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    initial begin
        #100000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        {rst_b, reg_wr, reg_rd, x_req, x_prog_space, x_stack_use, y_req, y_mac_word_read} = '0;
        {reg_addr, reg_wdata, x_base, x_step, y_base} = '0;
        y_step = 16'h0002;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_masks();
        t_circ();
        t_bitrev();
        t_stack();
        complete_run();
    end
endmodule : test_crag_regs
